// >>> src/twcsp_device.sv
// Purpose: Device end of the three-wire configuration serial port
// Assumes: serial_clock toggles only while chip_select is high
// Notes:   Link logic on serial_clock, core logic on clock
`default_nettype none

module twcsp_device
(
    // Core clock and reset
    input  wire logic                              clock,
    input  wire logic                              rst,
    // Link to the host
    twcsp_if.dev_mp                                link,
    // Word returned by reads
    input  wire logic [twcsp_pkg::EXT_BITS-1:0]   read_word,
    // Received write frames
    output logic                                   frame_valid,
    output logic [twcsp_pkg::CMD_BITS-1:0]        frame_cmd,
    output logic [twcsp_pkg::EXT_BITS-1:0]        frame_data,
    // Core status
    output logic                                   low_power,
    output logic                                   outputs_active,
    output logic                                   analog_power_down,
    output logic                                   program_unlocked
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic                              cmd_done;
        logic [2:0]                        ccnt;
        logic [twcsp_pkg::CMD_BITS-1:0]   cmd;
        logic [5:0]                        left;
        logic [1:0]                        sub;
        logic [twcsp_pkg::EXT_BITS-1:0]   shreg;
        logic                              drive;
        logic                              dout;
    } twcsp_frame_t;

    typedef struct packed {
        logic                              tgl;
        logic [twcsp_pkg::CMD_BITS-1:0]   hcmd;
        logic [twcsp_pkg::EXT_BITS-1:0]   hdata;
    } twcsp_hold_t;

    typedef struct packed {
        logic                              cs_s1;
        logic                              cs_s2;
        logic                              t_s1;
        logic                              t_s2;
        logic                              t_s3;
        logic [twcsp_pkg::EXT_BITS-1:0]   snap;
        logic                              sleep;
        logic                              unlocked;
        logic                              valid;
        logic [twcsp_pkg::CMD_BITS-1:0]   fcmd;
        logic [twcsp_pkg::EXT_BITS-1:0]   fdata;
    } twcsp_core_t;

    twcsp_frame_t                    f;
    twcsp_frame_t                    next_f;
    twcsp_hold_t                     h;
    twcsp_hold_t                     next_h;
    twcsp_core_t                     c;
    twcsp_core_t                     next_c;

    logic                            din;
    logic [twcsp_pkg::CMD_BITS-1:0]  cmd_shift;
    logic                            is_ext;
    logic                            is_wr;
    logic                            last_sub;
    logic [twcsp_pkg::EXT_BITS-1:0]  rword;
    logic [twcsp_pkg::EXT_BITS-1:0]  wword;

    // ************************************************************
    // Link decode
    // ************************************************************
    assign din       = link.bidir_data_line;
    assign cmd_shift = {f.cmd[twcsp_pkg::CMD_BITS-2:0], din};
    assign is_ext    = f.cmd[twcsp_pkg::CMD_EXT_POS];
    assign is_wr     = f.cmd[twcsp_pkg::CMD_WRITE_POS];
    assign last_sub  = !is_ext || (f.sub == 2'(twcsp_pkg::EXT_CLOCKS_PER_BIT - 1));
    assign wword     = {f.shreg[twcsp_pkg::EXT_BITS-2:0], din};
    assign rword     = is_ext ? c.snap
                              : {{(twcsp_pkg::EXT_BITS-twcsp_pkg::NORM_BITS){1'b0}},
                                 c.snap[twcsp_pkg::NORM_BITS-1:0]};

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        next_f = f;
        next_h = h;
        next_c = c;
        // Command phase, one bit per rising edge
        if (!f.cmd_done)
        begin
            next_f.cmd  = cmd_shift;
            next_f.ccnt = f.ccnt + 3'h1;
            if (f.ccnt == 3'(twcsp_pkg::CMD_BITS - 1))
            begin
                next_f.cmd_done = 1'b1;
                next_f.left     = cmd_shift[twcsp_pkg::CMD_EXT_POS]
                                ? 6'(twcsp_pkg::EXT_BITS)
                                : 6'(twcsp_pkg::NORM_BITS);
            end
        end
        // Data phase
        else if (f.left != 6'h0)
        begin
            next_f.sub = last_sub ? 2'h0 : f.sub + 2'h1;
            if (is_wr)
            begin
                if (last_sub)
                begin
                    next_f.shreg = wword;
                    next_f.left  = f.left - 6'h1;
                    if (f.left == 6'h1)
                    begin
                        next_h.tgl   = !h.tgl;
                        next_h.hcmd  = f.cmd;
                        next_h.hdata = wword;
                    end
                end
            end
            else
            begin
                if (f.sub == 2'h0)
                begin
                    next_f.drive = 1'b1;
                    next_f.dout  = rword[f.left - 6'h1];
                end
                if (last_sub)
                begin
                    next_f.left = f.left - 6'h1;
                end
            end
        end
        else
        begin
            next_f.drive = 1'b0;
        end

        // Core side crossing
        next_c.cs_s1 = link.chip_select;
        next_c.cs_s2 = c.cs_s1;
        next_c.t_s1  = h.tgl;
        next_c.t_s2  = c.t_s1;
        next_c.t_s3  = c.t_s2;
        next_c.valid = 1'b0;
        // Read word frozen while a frame runs
        if (!c.cs_s2)
        begin
            next_c.snap = read_word;
        end
        if (c.t_s2 != c.t_s3)
        begin
            next_c.valid = 1'b1;
            next_c.fcmd  = h.hcmd;
            next_c.fdata = h.hdata;
            if (h.hcmd == twcsp_pkg::CMD_CONFIG_WRITE)
            begin
                next_c.sleep = h.hdata[twcsp_pkg::LOW_POWER_POS];
            end
            if (h.hcmd == twcsp_pkg::CMD_PROGRAM_UNLOCK)
            begin
                next_c.unlocked = 1'b1;
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge link.serial_clock or negedge link.chip_select)
    begin
        if (!link.chip_select)
        begin
            f <= '0;
        end
        else
        begin
            f <= next_f;
        end
    end

    always_ff @(posedge link.serial_clock or posedge rst)
    begin
        if (rst)
        begin
            h <= '0;
        end
        else
        begin
            h <= next_h;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            c <= '0;
        end
        else
        begin
            c <= next_c;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign link.dev_data_out = f.dout;
    assign link.dev_data_oe  = f.drive;
    assign frame_valid       = c.valid;
    assign frame_cmd         = c.fcmd;
    assign frame_data        = c.fdata;
    assign low_power         = c.sleep;
    assign outputs_active    = !c.sleep;
    assign analog_power_down = c.sleep;
    assign program_unlocked  = c.unlocked;

endmodule

`default_nettype wire

// >>> src/twcsp_host.sv
// Purpose: Host end of the three-wire configuration serial port
// Assumes: clock runs at 10 MHz
// Notes:   Serial clock made by a divider from clock
`default_nettype none

module twcsp_host
(
    // Clock and reset
    input  wire logic                              clock,
    input  wire logic                              rst,
    // Link to the device
    twcsp_if.host_mp                               link,
    // Request
    input  wire logic                              req_valid,
    output logic                                   req_ready,
    input  wire logic [twcsp_pkg::CMD_BITS-1:0]   req_cmd,
    input  wire logic [twcsp_pkg::EXT_BITS-1:0]   req_data,
    input  wire twcsp_pkg::twcsp_rate_t            req_rate,
    // Answer
    output logic                                   done,
    output logic [twcsp_pkg::EXT_BITS-1:0]        rd_data,
    output logic                                   unlocked
);

    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [5:0] {
        IDLE  = 6'h01,
        SETUP = 6'h02,
        HIGH  = 6'h04,
        LOW   = 6'h08,
        HOLD  = 6'h10,
        GAP   = 6'h20
    } twcsp_state_t;

    typedef struct packed {
        twcsp_state_t                       state;
        logic [9:0]                         hc;
        logic [9:0]                         half;
        logic                               cs;
        logic                               sclk;
        logic                               oe;
        logic [twcsp_pkg::FRAME_BITS-1:0]  tx;
        logic [twcsp_pkg::EXT_BITS-1:0]    rx;
        logic                               ext;
        logic                               wr;
        logic                               dphase;
        logic [2:0]                         ccnt;
        logic [1:0]                         sub;
        logic [5:0]                         left;
        logic                               done;
        logic [twcsp_pkg::EXT_BITS-1:0]    rdata;
        logic                               unlocked;
        logic                               pend;
        logic [twcsp_pkg::CMD_BITS-1:0]    pcmd;
        logic [twcsp_pkg::EXT_BITS-1:0]    pdata;
        twcsp_pkg::twcsp_rate_t             prate;
    } twcsp_host_t;

    twcsp_host_t                      q;
    twcsp_host_t                      next_q;

    logic                             want_unlock;
    logic                             go;
    logic [twcsp_pkg::CMD_BITS-1:0]  go_cmd;
    logic [twcsp_pkg::EXT_BITS-1:0]  go_data;
    twcsp_pkg::twcsp_rate_t           go_rate;
    logic                             go_ext;
    logic                             tick;
    logic                             last_sub;

    // ************************************************************
    // Request selection
    // ************************************************************
    assign want_unlock = !q.pend && req_cmd[twcsp_pkg::CMD_EXT_POS] && !q.unlocked;
    assign go          = q.state == IDLE && (q.pend || req_valid);
    assign go_cmd      = q.pend ? q.pcmd : (want_unlock ? twcsp_pkg::CMD_PROGRAM_UNLOCK : req_cmd);
    assign go_data     = q.pend ? q.pdata
                       : (want_unlock ? {{(twcsp_pkg::EXT_BITS-twcsp_pkg::NORM_BITS){1'b0}},
                                         twcsp_pkg::UNLOCK_KEY} : req_data);
    assign go_rate     = q.pend ? q.prate : req_rate;
    assign go_ext      = go_cmd[twcsp_pkg::CMD_EXT_POS];
    assign tick        = q.hc == q.half - 10'h1;
    assign last_sub    = !q.ext || q.sub == 2'(twcsp_pkg::EXT_CLOCKS_PER_BIT - 1);
    assign req_ready   = q.state == IDLE && !q.pend;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        next_q      = q;
        next_q.done = 1'b0;
        if (q.state != IDLE)
        begin
            next_q.hc = tick ? 10'h0 : q.hc + 10'h1;
        end
        unique case (q.state)
            IDLE:
            begin
                if (go)
                begin
                    next_q.pend     = want_unlock;
                    next_q.pcmd     = req_cmd;
                    next_q.pdata    = req_data;
                    next_q.prate    = req_rate;
                    next_q.unlocked = q.unlocked || go_cmd == twcsp_pkg::CMD_PROGRAM_UNLOCK;
                    next_q.state    = SETUP;
                    next_q.hc       = 10'h0;
                    next_q.cs       = 1'b1;
                    next_q.oe       = 1'b1;
                    next_q.ext      = go_ext;
                    next_q.wr       = go_cmd[twcsp_pkg::CMD_WRITE_POS];
                    next_q.dphase   = 1'b0;
                    next_q.ccnt     = 3'h0;
                    next_q.sub      = 2'h0;
                    next_q.rx       = '0;
                    next_q.left     = go_ext ? 6'(twcsp_pkg::EXT_BITS) : 6'(twcsp_pkg::NORM_BITS);
                    next_q.tx       = go_ext ? {go_cmd, go_data}
                                    : {go_cmd, go_data[twcsp_pkg::NORM_BITS-1:0],
                                       {(twcsp_pkg::EXT_BITS-twcsp_pkg::NORM_BITS){1'b0}}};
                    if (!go_ext)
                    begin
                        next_q.half = twcsp_pkg::NORMAL_HALF;
                    end
                    else if (go_rate == twcsp_pkg::RATE_PROGRAM)
                    begin
                        next_q.half = twcsp_pkg::PROGRAM_HALF;
                    end
                    else if (go_rate == twcsp_pkg::RATE_READBACK)
                    begin
                        next_q.half = twcsp_pkg::READBACK_HALF;
                    end
                    else
                    begin
                        next_q.half = twcsp_pkg::EXTENDED_HALF;
                    end
                end
            end
            SETUP, LOW:
            begin
                if (tick)
                begin
                    next_q.sclk  = 1'b1;
                    next_q.state = HIGH;
                end
            end
            HIGH:
            begin
                if (tick)
                begin
                    next_q.sclk  = 1'b0;
                    next_q.state = LOW;
                    if (!q.dphase)
                    begin
                        next_q.tx   = q.tx << 1;
                        next_q.ccnt = q.ccnt + 3'h1;
                        if (q.ccnt == 3'(twcsp_pkg::CMD_BITS - 1))
                        begin
                            next_q.dphase = 1'b1;
                            next_q.oe     = q.wr;
                        end
                    end
                    else
                    begin
                        next_q.sub = last_sub ? 2'h0 : q.sub + 2'h1;
                        if (last_sub)
                        begin
                            next_q.tx   = q.tx << 1;
                            next_q.rx   = {q.rx[twcsp_pkg::EXT_BITS-2:0], link.bidir_data_line};
                            next_q.left = q.left - 6'h1;
                            if (q.left == 6'h1)
                            begin
                                next_q.state = HOLD;
                            end
                        end
                    end
                end
            end
            HOLD:
            begin
                if (tick)
                begin
                    next_q.cs    = 1'b0;
                    next_q.oe    = 1'b0;
                    next_q.state = GAP;
                end
            end
            GAP:
            begin
                if (tick)
                begin
                    next_q.state = IDLE;
                    next_q.done  = !q.pend;
                    next_q.rdata = q.rx;
                end
            end
            default:
            begin
                next_q.state = IDLE;
            end
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            q       <= '0;
            q.state <= IDLE;
            q.half  <= twcsp_pkg::NORMAL_HALF;
        end
        else
        begin
            q <= next_q;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign link.chip_select   = q.cs;
    assign link.serial_clock  = q.sclk;
    assign link.host_data_out = q.tx[twcsp_pkg::FRAME_BITS-1];
    assign link.host_data_oe  = q.oe;
    assign done               = q.done;
    assign rd_data            = q.rdata;
    assign unlocked           = q.unlocked;

endmodule

`default_nettype wire

// >>> src/twcsp_if.sv
// Purpose: Three-wire link between host end and device end
// Assumes: Shared data line has a pull-up
// Notes:   Line level resolved here from both enables
`default_nettype none

interface twcsp_if;
    logic chip_select;
    logic serial_clock;
    logic host_data_out;
    logic host_data_oe;
    logic dev_data_out;
    logic dev_data_oe;
    logic bidir_data_line;

    // Pull-up when nobody drives
    assign bidir_data_line = host_data_oe ? host_data_out : (dev_data_oe ? dev_data_out : 1'b1);

    modport host_mp (
        output chip_select,
        output serial_clock,
        output host_data_out,
        output host_data_oe,
        input  bidir_data_line
    );

    modport dev_mp (
        input  chip_select,
        input  serial_clock,
        input  bidir_data_line,
        output dev_data_out,
        output dev_data_oe
    );
endinterface

`default_nettype wire

// >>> src/twcsp_pkg.sv
// Purpose: Shared constants of the three-wire configuration serial port
// Assumes: Host end runs on a 10 MHz clock
// Notes:   Frame layout, command codes and clock-rate limits
`default_nettype none

package twcsp_pkg;

    // ************************************************************
    // Frame layout
    // ************************************************************
    localparam int CMD_BITS           = 5;
    localparam int NORM_BITS          = 16;
    localparam int EXT_BITS           = 46;
    localparam int FRAME_BITS         = CMD_BITS + EXT_BITS;
    localparam int EXT_CLOCKS_PER_BIT = 4;
    localparam int CMD_WRITE_POS      = 4;
    localparam int CMD_EXT_POS        = 3;
    localparam int LOW_POWER_POS      = 15;

    // ************************************************************
    // Command codes
    // ************************************************************
    localparam logic [4:0]  CMD_CONFIG_WRITE   = 5'h17;
    localparam logic [4:0]  CMD_PROGRAM_UNLOCK = 5'h10;
    localparam logic [15:0] UNLOCK_KEY         = 16'h8cae;

    // ************************************************************
    // Clock rates and derived half periods
    // ************************************************************
    localparam int CLOCK_HZ                          = 10_000_000;
    localparam int NORMAL_CLOCK_RATE_MAX_HZ          = 6_000_000;
    localparam int EXTENDED_ACCESS_CLOCK_RATE_MAX_HZ = 6_000;
    localparam int PROGRAM_CLOCK_RATE_MAX_HZ         = 650_000;
    localparam int READBACK_CLOCK_RATE_MAX_HZ        = 162_500;
    localparam int HALF_W                            = 10;

    localparam logic [9:0] NORMAL_HALF   =
        10'((CLOCK_HZ + 2 * NORMAL_CLOCK_RATE_MAX_HZ - 1) / (2 * NORMAL_CLOCK_RATE_MAX_HZ));
    localparam logic [9:0] EXTENDED_HALF =
        10'((CLOCK_HZ + 2 * EXTENDED_ACCESS_CLOCK_RATE_MAX_HZ - 1) / (2 * EXTENDED_ACCESS_CLOCK_RATE_MAX_HZ));
    localparam logic [9:0] PROGRAM_HALF  =
        10'((CLOCK_HZ + 2 * PROGRAM_CLOCK_RATE_MAX_HZ - 1) / (2 * PROGRAM_CLOCK_RATE_MAX_HZ));
    localparam logic [9:0] READBACK_HALF =
        10'((CLOCK_HZ + 2 * READBACK_CLOCK_RATE_MAX_HZ - 1) / (2 * READBACK_CLOCK_RATE_MAX_HZ));

    typedef enum logic [1:0] {
        RATE_ACCESS   = 2'h0,
        RATE_PROGRAM  = 2'h1,
        RATE_READBACK = 2'h2
    } twcsp_rate_t;

endpackage

`default_nettype wire

// >>> verif/three_wire_config_serial_port_tb.sv
// Purpose: Bench joining host and device ends
// Assumes: Extended frames run at program and readback rates
// Notes:   Writes, reads, sleep and unlock
`default_nettype none
module three_wire_config_serial_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // Ends, link, checker and tests
    // ************************************************************
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        req_valid = 1'b0;
    logic [4:0]  req_cmd = 5'h00;
    logic [45:0] req_data = 46'h0;
    twcsp_pkg::twcsp_rate_t req_rate = twcsp_pkg::RATE_ACCESS;
    logic [50:0] fexp;
    logic [50:0] exp_q[$];
    logic [45:0] read_word = 46'h0;
    logic [45:0] rd_data, frame_data;
    logic [4:0]  frame_cmd;
    logic        req_ready, done, unlocked, frame_valid, low_power, outputs_active, analog_power_down, program_unlocked;
    int          miscompares = 0, comparisons = 0, cycles = 0, nfv = 0, exp_lp = 0, exp_unl = 0;
    int          since = 0, per = 0, sclk_d = 0;
    twcsp_if link ();
    twcsp_host i_twcsp_host (.clock, .rst, .link, .req_valid, .req_ready, .req_cmd, .req_data,
        .req_rate, .done, .rd_data, .unlocked);
    twcsp_device i_twcsp_device (.clock, .rst, .link, .read_word, .frame_valid, .frame_cmd, .frame_data,
        .low_power, .outputs_active, .analog_power_down, .program_unlocked);
    twcsp_sva i_twcsp_sva (.clock, .rst, .chip_select(link.chip_select), .serial_clock(link.serial_clock),
        .host_data_oe(link.host_data_oe), .dev_data_out(link.dev_data_out), .dev_data_oe(link.dev_data_oe));
    always #50 clock = ~clock;
    task automatic print_verdict();
        $display("miscompares %0d comparisons %0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(negedge clock)
    begin
        cycles++;
        since++;
        if (link.serial_clock === 1'b1 && sclk_d == 0)
        begin
            per = since;
            since = 0;
        end
        sclk_d = int'(link.serial_clock === 1'b1);
        if (frame_valid === 1'b1)
        begin
            nfv++;
            fexp = (exp_q.size() > 0) ? exp_q.pop_front() : 51'h0;
            check(46'(frame_cmd), 46'(fexp[50:46]));
            check(frame_data, fexp[45:0]);
        end
        if (cycles == 20000)
        begin
            miscompares++;
            print_verdict();
        end
    end
    task automatic check(input logic [45:0] seen, input logic [45:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic [4:0] c, input logic [45:0] d, input twcsp_pkg::twcsp_rate_t r);
        int n;
        int pushed;
        int fmax;
        n = nfv;
        pushed = 0;
        check(46'(req_ready), 46'h1);
        if (c[3] && exp_unl == 0)
        begin
            exp_q.push_back({twcsp_pkg::CMD_PROGRAM_UNLOCK, 30'h0, twcsp_pkg::UNLOCK_KEY});
            pushed++;
            exp_unl = 1;
        end
        if (c[4])
        begin
            exp_q.push_back({c, c[3] ? d : {30'h0, d[15:0]}});
            pushed++;
        end
        read_word = 46'({$urandom(), $urandom()});
        req_cmd = c;
        req_data = d;
        req_rate = r;
        req_valid = 1'b1;
        @(posedge clock);
        #1 req_valid = 1'b0;
        while (done !== 1'b1)
        begin
            @(posedge clock);
            #1;
        end
        repeat (6) @(posedge clock);
        #1;
        if (c == twcsp_pkg::CMD_CONFIG_WRITE)
            exp_lp = int'(d[15]);
        if (c == twcsp_pkg::CMD_PROGRAM_UNLOCK)
            exp_unl = 1;
        fmax = !c[3] ? twcsp_pkg::NORMAL_CLOCK_RATE_MAX_HZ
             : r == twcsp_pkg::RATE_PROGRAM ? twcsp_pkg::PROGRAM_CLOCK_RATE_MAX_HZ
             : r == twcsp_pkg::RATE_READBACK ? twcsp_pkg::READBACK_CLOCK_RATE_MAX_HZ
             : twcsp_pkg::EXTENDED_ACCESS_CLOCK_RATE_MAX_HZ;
        check(46'(nfv - n), 46'(pushed));
        check(46'(exp_q.size()), 46'h0);
        if (!c[4])
            check(rd_data, c[3] ? read_word : {30'h0, read_word[15:0]});
        check(46'(per * 100 * fmax >= 1_000_000_000), 46'h1);
        check(46'(unlocked), 46'(exp_unl));
        check(46'(low_power), 46'(exp_lp));
        check(46'(outputs_active), 46'(1 - exp_lp));
        check(46'(analog_power_down), 46'(exp_lp));
        check(46'(program_unlocked), 46'(exp_unl));
    endtask
    initial
    begin
        void'($urandom(32'h7ec9));
        repeat (16) @(posedge clock);
        #1 rst = 1'b0;
        repeat (4) @(posedge clock);
        #1;
        xfer(twcsp_pkg::CMD_CONFIG_WRITE, 46'h8000, twcsp_pkg::RATE_ACCESS);
        xfer(twcsp_pkg::CMD_CONFIG_WRITE, 46'h0000, twcsp_pkg::RATE_ACCESS);
        xfer(5'h1f, 46'({$urandom(), $urandom()}), twcsp_pkg::RATE_PROGRAM);
        xfer(5'h0f, 46'h0, twcsp_pkg::RATE_READBACK);
        xfer(twcsp_pkg::CMD_PROGRAM_UNLOCK, 46'(twcsp_pkg::UNLOCK_KEY), twcsp_pkg::RATE_ACCESS);
        for (int i = 0; i < 12; i++)
            xfer({i[0], 1'b0, 3'($urandom())}, 46'($urandom()), twcsp_pkg::RATE_ACCESS);
        print_verdict();
    end
endmodule
`default_nettype wire

// >>> verif/twcsp_sva.sv
// Purpose: Link checks for the three-wire serial port
// Assumes: Host clock samples the whole link
// Notes:   Counts serial clock rises per frame
`default_nettype none
module twcsp_sva
(
    // Clock, reset and link
    input wire logic clock,
    input wire logic rst,
    input wire logic chip_select,
    input wire logic serial_clock,
    input wire logic host_data_oe,
    input wire logic dev_data_out,
    input wire logic dev_data_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // Rise counter and properties
    // ************************************************************
    logic [7:0] rises;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    always_ff @(posedge clock)
        if (rst || !chip_select)
            rises <= 8'h00;
        else if ($rose(serial_clock))
            rises <= rises + 8'h01;
    desel_float_a: assert property (!chip_select |-> !dev_data_oe) else $error("driven while deselected");
    idle_clock_a: assert property (!chip_select |-> !serial_clock) else $error("clock outside frame");
    select_first_a: assert property ($rose(serial_clock) |-> $past(chip_select)) else $error("clock before select");
    one_driver_a: assert property (host_data_oe |-> !dev_data_oe) else $error("line contention");
    read_start_a: assert property ($rose(dev_data_oe) |-> $rose(serial_clock) && rises == 8'h05)
        else $error("read drive misplaced");
    launch_rise_a: assert property (dev_data_oe && $past(dev_data_oe) && !$rose(serial_clock) |-> $stable(dev_data_out))
        else $error("data changed off rise");
    frame_len_a: assert property ($fell(chip_select) |-> rises == 8'h15 || rises == 8'hbd)
        else $error("bad frame length");
    read_end_a: assert property ($fell(dev_data_oe) |-> !chip_select || $rose(serial_clock))
        else $error("early release");
    cover property ($rose(dev_data_oe));
    cover property ($fell(chip_select) && rises == 8'h15);
    cover property ($rose(chip_select));
    cover property ($fell(chip_select) && rises == 8'hbd);
endmodule
`default_nettype wire
